//--- include/intc_map.svh
// register offsets, field positions and reset values of the interrupt controller
// assumes inclusion by the design file only
`ifndef INTC_MAP_SVH
`define INTC_MAP_SVH
`define OFS_EDGE_SEL 3'h0
`define OFS_CTRL_A 3'h1
`define OFS_CTRL_B 3'h2
`define OFS_TMR0_GRP 3'h3
`define OFS_TMR1_GRP 3'h4
`define OFS_VECTOR 3'h5
`define OFS_STATUS 3'h6
`define RESET_BYTE 8'h00
`define EDGE_OFF 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define EDGE_MASK 8'h03
`define CTRL_A_MASK 8'h7F
`define GRP_MASK 8'h33
`define A_GROUP0_FLAG 6
`define A_TICK0_FLAG 5
`define A_EXT_FLAG 4
`define A_GROUP0_EN 3
`define A_TICK0_EN 2
`define A_EXT_EN 1
`define A_GLOBAL_EN 0
`define B_TICK1_FLAG 7
`define B_CONV_FLAG 6
`define B_NVM_FLAG 5
`define B_GROUP1_FLAG 4
`define B_TICK1_EN 3
`define B_CONV_EN 2
`define B_NVM_EN 1
`define B_GROUP1_EN 0
`define G_CMPA_FLAG 5
`define G_CMPP_FLAG 4
`define G_CMPA_EN 1
`define G_CMPP_EN 0
`endif

//--- include/intc_pkg.sv
// types shared by the interrupt controller and its bench
// assumes intc_map.svh on the include path
package intc_pkg;
  typedef enum logic [2:0] {
    src_ext = 3'h0,
    src_tick0 = 3'h1,
    src_group0 = 3'h2,
    src_tick1 = 3'h3,
    src_conv = 3'h4,
    src_nvm = 3'h5,
    src_group1 = 3'h6,
    src_none = 3'h7
  } source_t;
  typedef enum logic [1:0] {
    st_run = 2'h1,
    st_ack = 2'h2
  } state_t;
endpackage : intc_pkg

//--- logic/intc_core.sv
// interrupt controller: flags, enables, priority pick, vector call and return, wake
// assumes a core that obeys take_irq pulses and reports stack fullness and reti
//
// Operation
// [R1] edge field: 00 off, 01 rising, 10 falling, 11 both edges
// [R2] control A bits 6..0: group0, tick0, ext flags; group0, tick0, ext, global enables
// [R3] control B bits 7..0: tick1, conv, nvm, group1 flags then their enables
// [R4] timer0 group: A flag bit5, P flag bit4, A enable bit1, P enable bit0
// [R5] timer1 group uses the same layout as timer0 group
// [R6] unimplemented bits ignore writes and read zero
// [R7] source event sets its flag regardless of enables
// [R8] flag with enable clear stays set but never vectors
// [R9] global enable low blocks all acceptance
// [R10] acceptance pushes next address and loads pc with the source vector
// [R11] return instruction pops saved pc and resumes
// [R12] service entry clears global enable
// [R13] requests during blocking still set and hold flags
// [R14] software may set global enable inside a routine for nesting
// [R15] full stack blocks acceptance until the pointer drops
// [R16] own vectors per source; comparator sources share their group vector
// [R17] newly set flag wakes from sleep or idle; earlier flags do not
// [R18] group flag sets when any comparator flag of its group sets
// [R19] serving a group clears group flag, comparator flags stay
// [R20] serving an independent source clears its flag at the branch
// [R21] simultaneous requests accepted one at a time in fixed priority
// [R22] all flags and enables writable; writing one to a flag pends a request
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "intc_map.svh"
module intc_core #(
  parameter int PC_W = 12,
  parameter logic [11:0] VEC_BASE = 12'h004,
  parameter logic [11:0] VEC_STEP = 12'h004
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ext_pin,
  input wire logic tick0_evt,
  input wire logic tick1_evt,
  input wire logic conv_done_evt,
  input wire logic nvm_write_evt,
  input wire logic tmr0_cmpa_evt,
  input wire logic tmr0_cmpp_evt,
  input wire logic tmr1_cmpa_evt,
  input wire logic tmr1_cmpp_evt,
  input wire logic insn_boundary,
  input wire logic [PC_W-1:0] next_pc,
  input wire logic stack_full,
  input wire logic reti_exec,
  input wire logic [PC_W-1:0] stack_top,
  input wire logic low_power,
  output logic take_irq,
  output logic push_en,
  output logic [PC_W-1:0] push_data,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  output logic pop_en,
  output intc_pkg::source_t vector_src,
  output logic wake_up
);
  import intc_pkg::*;

  initial begin
    if (PC_W < 12 || PC_W > 16) $error("intc_core: PC_W must be 12..16");
  end

  logic [7:0] edge_select_reg;
  logic [7:0] irq_ctrl_reg_a;
  logic [7:0] irq_ctrl_reg_b;
  logic [7:0] timer0_group_reg;
  logic [7:0] timer1_group_reg;
  logic ext_pin_reg;
  logic [7:0] rdata_reg;
  logic [PC_W-1:0] push_reg;
  logic [PC_W-1:0] pc_reg;
  logic take_reg;
  logic pop_reg;
  source_t src_reg;
  state_t state_reg;
  state_t state_next;
  logic wake_reg;
  logic low_power_reg;

  // write decode
  wire wr_edge = reg_wr && reg_addr == `OFS_EDGE_SEL;
  wire wr_a = reg_wr && reg_addr == `OFS_CTRL_A;
  wire wr_b = reg_wr && reg_addr == `OFS_CTRL_B;
  wire wr_g0 = reg_wr && reg_addr == `OFS_TMR0_GRP;
  wire wr_g1 = reg_wr && reg_addr == `OFS_TMR1_GRP;

  // edge detect on a pin taken as synchronous
  wire [1:0] edge_sel = edge_select_reg[1:0];
  wire rise = ext_pin && !ext_pin_reg;
  wire fall = !ext_pin && ext_pin_reg;
  wire ext_evt = (edge_sel == `EDGE_RISE && rise) || // see [R1]
                 (edge_sel == `EDGE_FALL && fall) ||
                 (edge_sel == `EDGE_BOTH && (rise || fall));

  // group flag sets on any comparator event of the group, even with that comparator flag already set
  wire g0_cmp_set = tmr0_cmpa_evt || tmr0_cmpp_evt; // see [R18]
  wire g1_cmp_set = tmr1_cmpa_evt || tmr1_cmpp_evt; // see [R18]

  // pending and enabled; global enable and stack gate only the acceptance below
  wire glob_en = irq_ctrl_reg_a[`A_GLOBAL_EN];
  wire [6:0] pend;
  assign pend[0] = irq_ctrl_reg_a[`A_EXT_FLAG] && irq_ctrl_reg_a[`A_EXT_EN]; // see [R8]
  assign pend[1] = irq_ctrl_reg_a[`A_TICK0_FLAG] && irq_ctrl_reg_a[`A_TICK0_EN];
  assign pend[2] = irq_ctrl_reg_a[`A_GROUP0_FLAG] && irq_ctrl_reg_a[`A_GROUP0_EN];
  assign pend[3] = irq_ctrl_reg_b[`B_TICK1_FLAG] && irq_ctrl_reg_b[`B_TICK1_EN];
  assign pend[4] = irq_ctrl_reg_b[`B_CONV_FLAG] && irq_ctrl_reg_b[`B_CONV_EN];
  assign pend[5] = irq_ctrl_reg_b[`B_NVM_FLAG] && irq_ctrl_reg_b[`B_NVM_EN];
  assign pend[6] = irq_ctrl_reg_b[`B_GROUP1_FLAG] && irq_ctrl_reg_b[`B_GROUP1_EN];

  // lowest index wins; fixed order
  function automatic source_t pick(input logic [6:0] p);
    source_t s;
    s = src_none;
    for (int i = 6; i >= 0; i--) begin
      if (p[i]) s = source_t'(3'(i));
    end
    return s;
  endfunction : pick

  wire source_t winner = pick(pend); // see [R21]
  // a return in flight owns the pc load, so acceptance waits one cycle for it
  wire accept = state_reg == st_run && insn_boundary && glob_en && // see [R9]
                !stack_full && !reti_exec && winner != src_none; // see [R15]
  // comparator sources reach here only through their group index
  wire [11:0] vec_addr = VEC_BASE + 12'(VEC_STEP * {9'h000, winner}); // see [R16]

  // clear by service of the accepted source; a fresh event wins over it
  wire clr_ext = accept && winner == src_ext; // see [R20]
  wire clr_t0 = accept && winner == src_tick0;
  wire clr_g0 = accept && winner == src_group0; // see [R19]
  wire clr_t1 = accept && winner == src_tick1;
  wire clr_cv = accept && winner == src_conv;
  wire clr_nv = accept && winner == src_nvm;
  wire clr_g1 = accept && winner == src_group1; // see [R19]

  // next control A: write first, then service clear, then events (set wins)
  logic [7:0] a_next;
  logic [7:0] b_next;
  logic [7:0] g0_next;
  logic [7:0] g1_next;
  always_comb begin
    a_next = wr_a ? (reg_wdata & `CTRL_A_MASK) : irq_ctrl_reg_a; // see [R2] [R22]
    if (clr_ext) a_next[`A_EXT_FLAG] = 1'b0;
    if (clr_t0) a_next[`A_TICK0_FLAG] = 1'b0;
    if (clr_g0) a_next[`A_GROUP0_FLAG] = 1'b0;
    if (accept) a_next[`A_GLOBAL_EN] = 1'b0; // see [R12] [R14]
    if (ext_evt) a_next[`A_EXT_FLAG] = 1'b1; // see [R7] [R13]
    if (tick0_evt) a_next[`A_TICK0_FLAG] = 1'b1;
    if (g0_cmp_set) a_next[`A_GROUP0_FLAG] = 1'b1;
    b_next = wr_b ? reg_wdata : irq_ctrl_reg_b; // see [R3] [R22]
    if (clr_t1) b_next[`B_TICK1_FLAG] = 1'b0;
    if (clr_cv) b_next[`B_CONV_FLAG] = 1'b0;
    if (clr_nv) b_next[`B_NVM_FLAG] = 1'b0;
    if (clr_g1) b_next[`B_GROUP1_FLAG] = 1'b0;
    if (tick1_evt) b_next[`B_TICK1_FLAG] = 1'b1; // see [R7]
    if (conv_done_evt) b_next[`B_CONV_FLAG] = 1'b1;
    if (nvm_write_evt) b_next[`B_NVM_FLAG] = 1'b1;
    if (g1_cmp_set) b_next[`B_GROUP1_FLAG] = 1'b1;
    // comparator flags are only cleared by software
    g0_next = wr_g0 ? (reg_wdata & `GRP_MASK) : timer0_group_reg; // see [R4] [R6]
    if (tmr0_cmpa_evt) g0_next[`G_CMPA_FLAG] = 1'b1;
    if (tmr0_cmpp_evt) g0_next[`G_CMPP_FLAG] = 1'b1;
    g1_next = wr_g1 ? (reg_wdata & `GRP_MASK) : timer1_group_reg; // see [R5] [R6]
    if (tmr1_cmpa_evt) g1_next[`G_CMPA_FLAG] = 1'b1;
    if (tmr1_cmpp_evt) g1_next[`G_CMPP_FLAG] = 1'b1;
    // a software write of one to a comparator flag pends its group too
    if (wr_g0 && (reg_wdata[`G_CMPA_FLAG] || reg_wdata[`G_CMPP_FLAG])) begin
      a_next[`A_GROUP0_FLAG] = 1'b1; // see [R22]
    end
    if (wr_g1 && (reg_wdata[`G_CMPA_FLAG] || reg_wdata[`G_CMPP_FLAG])) begin
      b_next[`B_GROUP1_FLAG] = 1'b1;
    end
  end

  // flags rising now; a flag already set before sleep never wakes
  wire [7:0] a_rise = a_next & ~irq_ctrl_reg_a;
  wire [7:0] b_rise = b_next & ~irq_ctrl_reg_b;
  wire new_flag = a_rise[`A_EXT_FLAG] || a_rise[`A_TICK0_FLAG] || // see [R17]
                  a_rise[`A_GROUP0_FLAG] || (b_rise & 8'hF0) != 8'h00;

  // read mux
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `OFS_EDGE_SEL: rd_mux = edge_select_reg & `EDGE_MASK; // see [R6]
      `OFS_CTRL_A: rd_mux = irq_ctrl_reg_a;
      `OFS_CTRL_B: rd_mux = irq_ctrl_reg_b;
      `OFS_TMR0_GRP: rd_mux = timer0_group_reg;
      `OFS_TMR1_GRP: rd_mux = timer1_group_reg;
      `OFS_VECTOR: rd_mux = {5'h00, src_reg};
      `OFS_STATUS: rd_mux = {6'h00, low_power_reg, state_reg == st_ack};
      default: rd_mux = `RESET_BYTE;
    endcase
  end

  // one cycle of acknowledge separates acceptances, so pc loads settle first
  always_comb begin
    case (state_reg)
      st_run: state_next = accept ? st_ack : st_run;
      st_ack: state_next = st_run;
      default: state_next = st_run;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      edge_select_reg <= `RESET_BYTE;
      irq_ctrl_reg_a <= `RESET_BYTE;
      irq_ctrl_reg_b <= `RESET_BYTE;
      timer0_group_reg <= `RESET_BYTE;
      timer1_group_reg <= `RESET_BYTE;
      ext_pin_reg <= 1'b0;
      state_reg <= st_run;
      low_power_reg <= 1'b0;
    end else begin
      if (wr_edge) edge_select_reg <= reg_wdata & `EDGE_MASK; // see [R6]
      irq_ctrl_reg_a <= a_next;
      irq_ctrl_reg_b <= b_next;
      timer0_group_reg <= g0_next;
      timer1_group_reg <= g1_next;
      ext_pin_reg <= ext_pin;
      state_reg <= state_next;
      low_power_reg <= low_power;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_reg <= `RESET_BYTE;
      take_reg <= 1'b0;
      push_reg <= '0;
      pc_reg <= '0;
      pop_reg <= 1'b0;
      src_reg <= src_none;
      wake_reg <= 1'b0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : rdata_reg;
      take_reg <= accept; // see [R10]
      pop_reg <= reti_exec; // see [R11]
      wake_reg <= low_power && new_flag; // see [R17]
      if (accept) begin
        push_reg <= next_pc; // see [R10]
        pc_reg <= PC_W'(vec_addr); // see [R16]
        src_reg <= winner;
      end else if (reti_exec) begin
        pc_reg <= stack_top; // see [R11]
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign take_irq = take_reg;
  assign push_en = take_reg;
  assign push_data = push_reg;
  assign pc_load = take_reg || pop_reg;
  assign pc_value = pc_reg;
  assign pop_en = pop_reg;
  assign vector_src = src_reg;
  assign wake_up = wake_reg;
endmodule : intc_core

//--- verification/core_model.sv
// core and stack model that sits on the far side of the interrupt controller
// assumes one clock, a synchronous active-high reset and push/pop pulses from the controller
`timescale 1ns/10ps
module core_model #(
  parameter int PC_W = 12,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic ret_req,
  input wire logic push_en,
  input wire logic [PC_W-1:0] push_data,
  input wire logic pop_en,
  output logic insn_boundary,
  output logic [PC_W-1:0] next_pc,
  output logic stack_full,
  output logic reti_exec,
  output logic [PC_W-1:0] stack_top
);
  logic [PC_W-1:0] mem [0:7];
  logic [PC_W-1:0] pc_reg;
  logic [1:0] phase_reg = 2'h0;
  int depth_reg;
  // a slow core opens an instruction boundary only one cycle in four
  assign insn_boundary = !slow || phase_reg == 2'h0;
  assign next_pc = pc_reg;
  assign stack_full = depth_reg >= DEPTH;
  // empty stack shows the inverse of the running pc, never a stale entry
  assign stack_top = (depth_reg > 0) ? mem[depth_reg - 1] : ~pc_reg;
  always @(posedge core_clk) begin
    phase_reg <= phase_reg + 2'h1;
    pc_reg <= srst ? '0 : pc_reg + PC_W'(1);
    reti_exec <= ret_req && !srst && depth_reg > 0;
    if (srst) depth_reg <= 0;
    else if (push_en) begin
      mem[depth_reg] <= push_data;
      depth_reg <= depth_reg + 1;
    end else if (pop_en) depth_reg <= depth_reg - 1;
  end
endmodule : core_model

//--- verification/intc_core_properties.sv
// port-level checks of the interrupt controller
// assumes it is bound into intc_core with the same parameters
`timescale 1ns/10ps
module intc_core_checker
  import intc_pkg::*;
#(
  parameter int PC_W = 12,
  parameter logic [11:0] VEC_BASE = 12'h004,
  parameter logic [11:0] VEC_STEP = 12'h004
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [2:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic insn_boundary,
  input wire logic [PC_W-1:0] next_pc,
  input wire logic stack_full,
  input wire logic reti_exec,
  input wire logic [PC_W-1:0] stack_top,
  input wire logic low_power,
  input wire logic take_irq,
  input wire logic push_en,
  input wire logic [PC_W-1:0] push_data,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_value,
  input wire logic pop_en,
  input wire intc_pkg::source_t vector_src,
  input wire logic wake_up
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  chk_push_with_take: assert property (push_en == take_irq)
    else $error("push and take differ");
  chk_take_spacing: assert property (take_irq |=> !take_irq)
    else $error("two acceptances back to back");
  chk_take_vector: assert property (take_irq |-> pc_load && vector_src != src_none
    && pc_value == PC_W'(VEC_BASE + VEC_STEP * 12'(vector_src))) else $error("bad vector");
  chk_push_next_pc: assert property (take_irq |-> push_data == $past(next_pc))
    else $error("pushed address is not next pc");
  chk_full_blocks: assert property (take_irq |-> !$past(stack_full) && $past(insn_boundary))
    else $error("accepted with full stack or off boundary");
  chk_return_pop: assert property (reti_exec |=> pop_en && pc_load
    && pc_value == $past(stack_top)) else $error("return did not restore pc");
  chk_pop_cause: assert property (pop_en |-> $past(reti_exec))
    else $error("pop without return");
  chk_wake_cause: assert property (wake_up |-> $past(low_power))
    else $error("wake outside low power");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : intc_core_checker
bind intc_core intc_core_checker #(.PC_W(PC_W), .VEC_BASE(VEC_BASE), .VEC_STEP(VEC_STEP)) u_checker (
  .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .insn_boundary(insn_boundary), .next_pc(next_pc),
  .stack_full(stack_full), .reti_exec(reti_exec), .stack_top(stack_top),
  .low_power(low_power), .take_irq(take_irq), .push_en(push_en), .push_data(push_data),
  .pc_load(pc_load), .pc_value(pc_value), .pop_en(pop_en), .vector_src(vector_src),
  .wake_up(wake_up));

//--- verification/mcu_interrupt_controller_bench.sv
// self-checking bench of the interrupt controller with a core model on its far side
// assumes intc_pkg, the design, the core model and the checker compiled before it
`timescale 1ns/10ps
module mcu_interrupt_controller_bench;
  import intc_pkg::*;
  `define CMP(a, b, m) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
  localparam logic [11:0] BASE = 12'h010;
  localparam logic [11:0] STEP = 12'h008;
  localparam logic [7:0] MASK [0:4] = '{8'h03, 8'h7F, 8'hFF, 8'h33, 8'h33};
  logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ext_pin = 1'b0;
  logic low_power = 1'b0, slow = 1'b0, ret_req = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, evt = 8'h00, reg_rdata, r, exp_a;
  logic [7:0] exp_r [0:4];
  logic take_irq, push_en, pc_load, pop_en, wake_up, insn_boundary, stack_full, reti_exec;
  logic [11:0] push_data, pc_value, next_pc, stack_top;
  source_t vector_src;
  logic [11:0] stk [$];
  int error_cnt = 0, check_count = 0, n_take = 0, n_wake = 0;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    n_take <= n_take + int'(take_irq === 1'b1);
    n_wake <= n_wake + int'(wake_up === 1'b1);
  end
  intc_core #(.PC_W(12), .VEC_BASE(BASE), .VEC_STEP(STEP)) u_dut (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin),
    .tick0_evt(evt[0]), .tick1_evt(evt[1]), .conv_done_evt(evt[2]), .nvm_write_evt(evt[3]),
    .tmr0_cmpa_evt(evt[4]), .tmr0_cmpp_evt(evt[5]), .tmr1_cmpa_evt(evt[6]),
    .tmr1_cmpp_evt(evt[7]), .insn_boundary(insn_boundary), .next_pc(next_pc),
    .stack_full(stack_full), .reti_exec(reti_exec), .stack_top(stack_top),
    .low_power(low_power), .take_irq(take_irq), .push_en(push_en), .push_data(push_data),
    .pc_load(pc_load), .pc_value(pc_value), .pop_en(pop_en), .vector_src(vector_src),
    .wake_up(wake_up));
  core_model #(.PC_W(12), .DEPTH(4)) u_core (
    .core_clk(core_clk), .srst(srst), .slow(slow), .ret_req(ret_req), .push_en(push_en),
    .push_data(push_data), .pop_en(pop_en), .insn_boundary(insn_boundary),
    .next_pc(next_pc), .stack_full(stack_full), .reti_exec(reti_exec), .stack_top(stack_top));
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CMP(reg_rdata, e, "register read")
  endtask : chk
  task automatic pulse(input logic [7:0] v);
    evt <= v;
    @(posedge core_clk);
    evt <= 8'h00;
    repeat (5) @(posedge core_clk);
  endtask : pulse
  // waits are bounded so a missing handshake shows as a mismatch, not a hang
  task automatic await(input bit want_pop);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while ((want_pop ? pop_en : take_irq) !== 1'b1 && n < 60);
  endtask : await
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    #(40 * 5000);
    error_cnt++;
    conclude();
  end
  initial begin
    void'($urandom(71));
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    for (int a = 0; a < 5; a++) chk(a[2:0], 8'h00);
    chk(3'h7, 8'h00);
    // global enable kept low so written flags only pend
    for (int k = 0; k < 3; k++) begin
      for (int a = 0; a < 5; a++) begin
        r = (a == 1) ? 8'($urandom) & 8'hFE : 8'($urandom);
        wr(a[2:0], r);
        exp_r[a] = r & MASK[a];
        if (a >= 3 && (r & 8'h30) != 8'h00) exp_r[a - 2] |= (a == 3) ? 8'h40 : 8'h10;
      end
      for (int a = 0; a < 5; a++) chk(a[2:0], exp_r[a]);
    end
    for (int a = 0; a < 5; a++) wr(a[2:0], 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(3'h0, 8'(m));
      ext_pin <= 1'b1;
      repeat (5) @(posedge core_clk);
      chk(3'h1, m[0] ? 8'h10 : 8'h00);
      wr(3'h1, 8'h00);
      ext_pin <= 1'b0;
      repeat (5) @(posedge core_clk);
      chk(3'h1, m[1] ? 8'h10 : 8'h00);
      wr(3'h1, 8'h00);
    end
    wr(3'h1, 8'h0E);
    wr(3'h2, 8'h0F);
    ext_pin <= 1'b1;
    pulse(8'hFF);
    `CMP(n_take, 0, "taken while disabled")
    chk(3'h1, 8'h7E);
    chk(3'h2, 8'hFF);
    exp_a = 8'h7E;
    for (int s = 0; s < 7; s++) begin
      slow <= 1'($urandom);
      wr(3'h1, exp_a | 8'h01);
      if (s >= 4) begin
        repeat (8) @(posedge core_clk);
        `CMP(n_take, s, "taken with full stack")
        ret_req <= 1'b1;
        @(posedge core_clk);
        ret_req <= 1'b0;
        await(1'b1);
        `CMP(pc_value, stk.pop_back(), "return address")
      end
      await(1'b0);
      `CMP(vector_src, source_t'(s), "priority order")
      `CMP(pc_value, BASE + STEP * 12'(s), "vector address")
      stk.push_back(push_data);
      if (s < 3) exp_a &= ~(8'h10 << s);
      chk(3'h1, exp_a);
    end
    chk(3'h2, 8'h0F);
    chk(3'h3, 8'h30);
    chk(3'h4, 8'h30);
    chk(3'h5, 8'h06);
    low_power <= 1'b1;
    pulse(8'h02);
    `CMP(n_wake, 1, "no wake on new flag")
    pulse(8'h02);
    `CMP(n_wake, 1, "wake on flag already set")
    chk(3'h6, 8'h02);
    conclude();
  end
endmodule : mcu_interrupt_controller_bench
